// file: dv/dfu_arbiter_model.sv
// memory arbiter model that fills and drains the refresh fifo
`timescale 1ns/1ps
module dfu_arbiter_model (
  input wire logic clock, rst, fetch_req, fetch_urgent, cpu_busy, drain,
  output logic [7:0] fifo_level
);
  logic grant;
  // a plain fetch loses to processor traffic, an urgent one wins
  assign grant = fetch_req && (fetch_urgent || !cpu_busy);
  always_ff @(posedge clock or posedge rst) begin
    if (rst) fifo_level <= 8'h00;
    else fifo_level <= fifo_level + {7'h00, grant} - {7'h00, drain && fifo_level != 8'h00};
  end
endmodule // dfu_arbiter_model

// file: dv/dfu_refresh_ctrl_bench.sv
// self-checking bench for the refresh urgency, offset and interlace block
`timescale 1ns/1ps
module dfu_refresh_ctrl_bench;
  import dfu_pkg::*;
  logic clock = 0, rst = 1, index_wr = 0, data_wr = 0, data_rd = 0, display_enable = 0, frame_start = 0;
  logic odd_frame = 0, cpu_busy = 0, drain = 1, fetch_req, fetch_urgent, interlace_on, vert_step_half;
  logic [7:0] port_wdata = 0, hchar_count = 0, fifo_low_mark = 8'hFF, fifo_level, port_rdata, index_q, v, lo, hi;
  logic [15:0] frame_line_offset;
  logic [31:0] seed = 43;
  int miscompares = 0, checks_done = 0;
  always #12.5 clock = ~clock;
  dfu_refresh_ctrl i_dut (.clock, .rst, .index_wr, .data_wr, .data_rd, .port_wdata, .port_rdata, .index_q,
    .hchar_count, .display_enable, .frame_start, .odd_frame, .fifo_level, .fifo_low_mark, .fetch_req,
    .fetch_urgent, .frame_line_offset, .interlace_on, .vert_step_half);
  dfu_arbiter_model i_arb (.clock, .rst, .fetch_req, .fetch_urgent, .cpu_busy, .drain, .fifo_level);
  function automatic logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction
  function automatic logic [15:0] offset_of(logic [7:0] h, logic [7:0] l);
    return {h, l};
  endfunction
  task automatic cyc(int n = 1);
    repeat (n) begin
      @(posedge clock);
      #2 cpu_busy = ^rnd();
    end
  endtask
  task automatic chk(logic [15:0] got, logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(logic [7:0] a, logic [7:0] d);
    index_wr = 1; port_wdata = a; cyc();
    index_wr = 0; data_wr = 1; port_wdata = d; cyc();
    data_wr = 0;
  endtask
  task automatic rd(logic [7:0] a, logic [7:0] exp);
    index_wr = 1; port_wdata = a; cyc();
    chk(index_q, {8'h00, a});
    index_wr = 0; data_rd = 1; cyc();
    data_rd = 0; cyc(2);
    chk(port_rdata, exp);
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    #50000 miscompares++;
    finish_test();
  end
  initial begin
    cyc(6); rst = 0;
    rd(8'h33, 8'h00);
    rd(8'h39, 8'hFF);
    rd(8'h50, 8'h00);
    chk(interlace_on, 0);
    lo = rnd(); hi = rnd();
    wr(8'h34, lo); wr(8'h35, hi);
    rd(8'h35, hi);
    chk(frame_line_offset, 16'h0000);
    frame_start = 1; cyc();
    frame_start = 0; cyc();
    chk(frame_line_offset, offset_of(hi, lo));
    $display("offset test done");
    v = rnd() & 8'h7F;
    wr(8'h39, v); cyc();
    chk(interlace_on, 1);
    odd_frame = 1; hchar_count = v; cyc(2);
    chk(vert_step_half, 1);
    odd_frame = 0; cyc();
    chk(vert_step_half, 0);
    wr(8'h39, 8'hFF); cyc();
    chk(interlace_on, 0);
    $display("interlace test done");
    v = (rnd() & 8'h7F) | 8'h10;
    wr(8'h33, v); hchar_count = v - 8'h01; display_enable = 1; cyc(2);
    chk(fetch_urgent, 0);
    hchar_count = v; cyc();
    chk(fetch_urgent, 1);
    hchar_count = v + 8'h01; cyc(2);
    chk(fetch_urgent, 1);
    fifo_low_mark = 8'h00; cyc(2);
    chk(fetch_urgent, 0);
    fifo_low_mark = 8'hFF; display_enable = 0; cyc(2);
    chk(fetch_urgent, 0);
    wr(8'h33, 8'hFF); cyc();
    chk(fetch_urgent, 1);
    $display("urgency test done");
    // low three bits of the high mark never stick
    wr(8'h27, 8'h0F); rd(8'h27, 8'h08);
    drain = 0; cyc(20);
    chk(fetch_req, 0);
    chk(fetch_urgent, 0);
    drain = 1; wr(8'h27, 8'hD0); cyc(2);
    chk(fetch_req, 1);
    $display("high mark test done");
    finish_test();
  end
endmodule // dfu_refresh_ctrl_bench

// file: dv/dfu_refresh_monitor.sv
// port assertions for the refresh controller
`timescale 1ns/1ps
module dfu_refresh_monitor (
  // clock, reset, register port and character count
  input wire logic clock, rst, index_wr, data_wr, data_rd,
  input wire logic [7:0] port_wdata, port_rdata, index_q, hchar_count,
  // timing and outputs
  input wire logic frame_start, odd_frame, fetch_req, fetch_urgent, interlace_on, vert_step_half,
  input wire logic [15:0] frame_line_offset
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  sequence idx_load;
    index_wr ##1 1'b1;
  endsequence
  // a write one or two edges back may still be working through to the step
  sequence step_held;
    vert_step_half && odd_frame && $stable(hchar_count) && !$past(data_wr) && !$past(data_wr, 2);
  endsequence
  idx_load_a: assert property (idx_load |-> index_q == $past(port_wdata)) else $error("index not loaded");
  idx_hold_a: assert property (!index_wr |=> $stable(index_q)) else $error("index moved");
  read_delay_a: assert property ($changed(port_rdata) |-> $past(data_rd, 2)) else $error("read data early");
  offset_frame_a: assert property ($changed(frame_line_offset) |-> $past(frame_start)) else $error("offset torn");
  step_odd_a: assert property (vert_step_half |-> $past(odd_frame)) else $error("step in even frame");
  step_hold_a: assert property (step_held |=> vert_step_half) else $error("step dropped");
  urgent_req_a: assert property (fetch_urgent |-> fetch_req) else $error("urgent without fetch");
  interlace_rise_a: assert property ($rose(interlace_on) |-> $past(data_wr) || $past(data_wr, 2)) else $error("bad on");
endmodule // dfu_refresh_monitor
bind dfu_refresh_ctrl dfu_refresh_monitor i_mon (.clock, .rst, .index_wr, .data_wr, .data_rd, .port_wdata,
  .port_rdata, .index_q, .hchar_count, .frame_start, .odd_frame, .fetch_req, .fetch_urgent, .interlace_on,
  .vert_step_half, .frame_line_offset);

// file: shared/dfu_pkg.sv
// constants for the display refresh urgency / offset / interlace block
package dfu_pkg;
  localparam logic [7:0] DFU_IDX_URGENT_START = 8'h33;
  localparam logic [7:0] DFU_IDX_OFFSET_LOW = 8'h34;
  localparam logic [7:0] DFU_IDX_OFFSET_HIGH = 8'h35;
  localparam logic [7:0] DFU_IDX_HALF_COUNT = 8'h39;
  localparam logic [7:0] DFU_IDX_HIGH_MARK = 8'h27;
  localparam logic [7:0] DFU_URGENT_START_RST = 8'h00;
  localparam logic [7:0] DFU_HALF_COUNT_RST = 8'hFF;
  localparam logic [7:0] DFU_HIGH_MARK_RST = 8'hD0;
  localparam logic [7:0] DFU_OFFSET_RST = 8'h00;
  localparam logic [7:0] DFU_ALL_ONES = 8'hFF;
  localparam int DFU_HIGH_MARK_LSB = 3;
  localparam int DFU_REG_COUNT = 5;
  localparam logic [2:0] DFU_SLOT_URGENT = 3'h0;
  localparam logic [2:0] DFU_SLOT_OFF_LO = 3'h1;
  localparam logic [2:0] DFU_SLOT_OFF_HI = 3'h2;
  localparam logic [2:0] DFU_SLOT_HALF = 3'h3;
  localparam logic [2:0] DFU_SLOT_HWM = 3'h4;
  localparam logic [2:0] DFU_SLOT_NONE = 3'h7;
  typedef enum logic [1:0] {
    DFU_LINE_IDLE = 2'b00,
    DFU_LINE_WAIT = 2'b01,
    DFU_LINE_ARMED = 2'b10
  } dfu_line_state_t;
endpackage

// file: verilog/dfu_refresh_ctrl.sv
// refresh fetch urgency, frame line offset and interlace half-field control
// Contract
// - urgent_start_position sets the character count where urgency may begin.
// - before that position and after display enable drops, fetches are low priority.
// - at the position, urgent fetch when FIFO occupancy is below low mark; the code gives no urgency there when display enable rises in that same cycle.
// - afterwards, until display enable drops, below-low-mark fetches are urgent.
// - start position of all ones makes every refresh fetch urgent.
// - urgent start register resets to zero.
// - frame offset is signed 16-bit scan lines; low byte in first register.
// - second offset register supplies offset bits fifteen to eight.
// - in odd interlaced frames vertical timing steps at the half-field count.
// - half-field count of all ones disables interlace; any other enables.
// - half-field count resets to all ones, interlace off.
// - fetching stops once FIFO occupancy rises above the high mark.
`timescale 1ns/1ps
module dfu_refresh_ctrl
  import dfu_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // index/data register port
  input wire logic index_wr,
  input wire logic data_wr,
  input wire logic data_rd,
  input wire logic [7:0] port_wdata,
  output logic [7:0] port_rdata,
  output logic [7:0] index_q,
  // display timing
  input wire logic [7:0] hchar_count,
  input wire logic display_enable,
  input wire logic frame_start,
  input wire logic odd_frame,
  // refresh FIFO status
  input wire logic [7:0] fifo_level,
  input wire logic [7:0] fifo_low_mark,
  // towards the memory arbiter
  output logic fetch_req,
  output logic fetch_urgent,
  // towards address generation and vertical timing
  output logic [15:0] frame_line_offset,
  output logic interlace_on,
  output logic vert_step_half
);
  logic [7:0] index_reg;
  logic [8*DFU_REG_COUNT-1:0] words;
  logic [7:0] rd_data;
  logic [7:0] urgent_start_position;
  logic [7:0] interlace_half_count;
  logic [7:0] refresh_fifo_high_mark;
  logic [15:0] displayed_frame_line_offset;
  logic below_low;
  logic above_high;
  logic always_urgent;
  dfu_line_state_t line_reg;
  dfu_line_state_t line_next;
  logic rd_pending_reg;

  function automatic logic [2:0] slot_of(input logic [7:0] idx);
    case (idx)
      DFU_IDX_URGENT_START: slot_of = DFU_SLOT_URGENT;
      DFU_IDX_OFFSET_LOW: slot_of = DFU_SLOT_OFF_LO;
      DFU_IDX_OFFSET_HIGH: slot_of = DFU_SLOT_OFF_HI;
      DFU_IDX_HALF_COUNT: slot_of = DFU_SLOT_HALF;
      DFU_IDX_HIGH_MARK: slot_of = DFU_SLOT_HWM;
      default: slot_of = DFU_SLOT_NONE;
    endcase
  endfunction

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      index_reg <= 8'h00;
    end else if (index_wr) begin
      index_reg <= port_wdata;
    end
  end

  dfu_reg_store u_store (
    .clock(clock),
    .rst(rst),
    .wr_en(data_wr && slot_of(index_reg) != DFU_SLOT_NONE),
    .wr_slot(slot_of(index_reg)),
    .wr_data(port_wdata),
    .rd_slot(slot_of(index_reg)),
    .rd_data(rd_data),
    .words(words)
  );

  assign urgent_start_position = words[8*DFU_SLOT_URGENT +: 8];
  assign interlace_half_count = words[8*DFU_SLOT_HALF +: 8];
  assign refresh_fifo_high_mark = words[8*DFU_SLOT_HWM +: 8];
  // low byte from the first register, high byte from the second
  assign displayed_frame_line_offset = {words[8*DFU_SLOT_OFF_HI +: 8], words[8*DFU_SLOT_OFF_LO +: 8]};
  assign below_low = fifo_level < fifo_low_mark;
  assign above_high = fifo_level > refresh_fifo_high_mark;
  assign always_urgent = urgent_start_position == DFU_ALL_ONES;

  // read data leaves the store one cycle after the strobe; port holds it
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rd_pending_reg <= 1'b0;
    end else begin
      rd_pending_reg <= data_rd;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      port_rdata <= 8'h00;
      index_q <= 8'h00;
    end else begin
      index_q <= index_wr ? port_wdata : index_reg;
      if (rd_pending_reg) begin
        port_rdata <= rd_data;
      end
    end
  end

  // per-line urgency window
  always_comb begin
    line_next = line_reg;
    case (line_reg)
      DFU_LINE_IDLE: begin
        if (display_enable) begin
          line_next = DFU_LINE_WAIT;
        end
      end
      DFU_LINE_WAIT: begin
        if (!display_enable) begin
          line_next = DFU_LINE_IDLE;
        end else if (hchar_count == urgent_start_position) begin
          line_next = DFU_LINE_ARMED;
        end
      end
      DFU_LINE_ARMED: begin
        if (!display_enable) begin
          line_next = DFU_LINE_IDLE;
        end
      end
      default: line_next = DFU_LINE_IDLE;
    endcase
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      line_reg <= DFU_LINE_IDLE;
    end else begin
      line_reg <= line_next;
    end
  end

  // the arbiter sees urgency with the request; low priority otherwise lets cpu and drawing engine win
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      fetch_req <= 1'b0;
      fetch_urgent <= 1'b0;
    end else begin
      fetch_req <= !above_high;
      if (above_high) begin
        fetch_urgent <= 1'b0;
      end else if (always_urgent) begin
        fetch_urgent <= 1'b1;
      end else if (display_enable && below_low &&
                   (line_reg == DFU_LINE_ARMED ||
                    (line_reg == DFU_LINE_WAIT && hchar_count == urgent_start_position))) begin
        fetch_urgent <= 1'b1;
      end else begin
        fetch_urgent <= 1'b0;
      end
    end
  end

  // offset latched whole at frame start so a half-written pair never shows
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      frame_line_offset <= 16'h0000;
    end else if (frame_start) begin
      frame_line_offset <= displayed_frame_line_offset;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      interlace_on <= 1'b0;
      vert_step_half <= 1'b0;
    end else begin
      interlace_on <= interlace_half_count != DFU_ALL_ONES;
      vert_step_half <= interlace_half_count != DFU_ALL_ONES && odd_frame &&
                        hchar_count == interlace_half_count;
    end
  end
endmodule // dfu_refresh_ctrl

// file: verilog/dfu_reg_store.sv
// small register store with registered read data
`timescale 1ns/1ps
module dfu_reg_store
  import dfu_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // write side
  input wire logic wr_en,
  input wire logic [2:0] wr_slot,
  input wire logic [7:0] wr_data,
  // read side
  input wire logic [2:0] rd_slot,
  output logic [7:0] rd_data,
  // every stored word, for the block's own logic
  output logic [8*DFU_REG_COUNT-1:0] words
);
  logic [7:0] mem_reg [DFU_REG_COUNT];

  function automatic logic [7:0] reset_value(input int slot);
    case (slot)
      0: reset_value = DFU_URGENT_START_RST;
      3: reset_value = DFU_HALF_COUNT_RST;
      4: reset_value = DFU_HIGH_MARK_RST;
      default: reset_value = DFU_OFFSET_RST;
    endcase
  endfunction

  genvar g;
  generate
    for (g = 0; g < DFU_REG_COUNT; g++) begin : g_word
      always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
          mem_reg[g] <= reset_value(g);
        end else if (wr_en && wr_slot == 3'(g)) begin
          if (g == int'(DFU_SLOT_HWM)) begin
            // low three bits are reserved and read as zero
            mem_reg[g] <= {wr_data[7:DFU_HIGH_MARK_LSB], 3'h0};
          end else begin
            mem_reg[g] <= wr_data;
          end
        end
      end
      assign words[8*g +: 8] = mem_reg[g];
    end
  endgenerate

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rd_data <= 8'h00;
    end else if (rd_slot < 3'(DFU_REG_COUNT)) begin
      rd_data <= mem_reg[rd_slot];
    end else begin
      rd_data <= 8'h00;
    end
  end
endmodule // dfu_reg_store
